//--- nac_appliance_model.sv
`timescale 1ns/1ps
// =========================================================
// Horn appliance on one circuit: records whole on and off runs
module nac_appliance_model (
    input wire logic sys_clk,
    input wire logic horn,
    input wire logic clr,
    output int minOn,
    output int maxOn,
    output int minOff,
    output int maxOff
);
    logic prevHorn;
    logic seen;
    int runLen;

    // First run after a clear is partial, so it is never scored
    always @(posedge sys_clk) begin
        prevHorn <= horn;
        if (clr) begin
            seen <= 1'b0;
            minOn <= 32'h7FFFFFFF;
            minOff <= 32'h7FFFFFFF;
            maxOn <= 32'h0;
            maxOff <= 32'h0;
        end else if (horn !== prevHorn) begin
            if (seen && prevHorn) begin
                minOn <= (runLen < minOn) ? runLen : minOn;
                maxOn <= (runLen > maxOn) ? runLen : maxOn;
            end else if (seen) begin
                minOff <= (runLen < minOff) ? runLen : minOff;
                maxOff <= (runLen > maxOff) ? runLen : maxOff;
            end
            seen <= 1'b1;
            runLen <= 1;
        end else begin
            runLen <= runLen + 1;
        end
    end
endmodule : nac_appliance_model

//--- nac_coding_pattern_generator.sv
`timescale 1ns/1ps
// Contract
// - March time pulses at 120 per minute
// - Temporal: three half-second pulses, long gap
// - California: ten seconds on, five off
// - One global selection for all outputs
// - Code only outputs mapped to coding zone
// - Two-stage: 20 per minute alert, then temporal
// - Auto alert on general-zone coded unsignalled outputs
// - Basic two-stage escalates after five quiet minutes
// - Canadian timers escalate on expiry
// - Canadian drill or evacuate escalates immediately
// - Canadian qualifying zone event escalates
// - Acknowledge or silence holds first stage
// - Canadian later alarm restarts full timer
// - Manual Canadian has no timer
// - Manual Canadian ignores later alarms
// - Manual: early reset or silence blocks second
// - Sync pattern only on main-board outputs
// - Sync horn-only silence spares strobe, fire resounds
// - Full-silence codes silence whole circuit
module nac_coding_pattern_generator #(
    parameter int TICK_CYCLES = nac_coding_pkg::TICK_CYCLES
) (
    input wire logic sys_clk,
    input wire logic rstn,
    input wire logic [3:0] codingSel,
    input wire logic [3:0] outActive,
    input wire logic [3:0] mapCodingZone,
    input wire logic [3:0] mapGeneralZone,
    input wire logic [3:0] mapAlarmSignal,
    input wire logic [3:0] mainBoard,
    input wire logic [3:0] strobeType,
    input wire logic [3:0] hornOnlySilence,
    input wire logic fireAlarm,
    input wire logic qualifyingEvent,
    input wire logic ackKey,
    input wire logic silenceKey,
    input wire logic panelReset,
    input wire logic drillIn,
    input wire logic manualEvacIn,
    output logic [3:0] hornOut,
    output logic [3:0] strobeOut,
    output logic generalStage
);
    import nac_coding_pkg::*;

    // =========================================================
    // Pattern decode helpers
    function automatic logic isSync(input logic [3:0] s);
        isSync = (s == SEL_SYNC_A) || (s == SEL_SYNC_B) || (s == SEL_SYNC_C);
    endfunction : isSync

    function automatic logic isCan(input logic [3:0] s);
        isCan = (s == SEL_CAN3) || (s == SEL_CAN5) || (s == SEL_CAN_MANUAL);
    endfunction : isCan

    // Period of the active pattern; general stage always runs temporal
    function automatic logic [MS_W-1:0] periodOf(input logic [3:0] s, input logic gen);
        if (gen || s == SEL_TEMPORAL) periodOf = MS_W'(TEMP_PERIOD_MS);
        else if (s == SEL_CALIFORNIA) periodOf = MS_W'(CAL_PERIOD_MS);
        else if (isSync(s)) periodOf = MS_W'(SYNC_PERIOD_MS);
        else if (s == SEL_TWO_STAGE || isCan(s)) periodOf = MS_W'(ALERT_PERIOD_MS);
        else periodOf = MS_W'(MARCH_PERIOD_MS);
    endfunction : periodOf

    function automatic logic patOn(input logic [3:0] s, input logic gen,
                                   input logic [MS_W-1:0] ms);
        if (gen || s == SEL_TEMPORAL) begin
            patOn = (ms < MS_W'(TEMP_STEP_MS))
                || (ms >= MS_W'(2 * TEMP_STEP_MS) && ms < MS_W'(3 * TEMP_STEP_MS))
                || (ms >= MS_W'(4 * TEMP_STEP_MS) && ms < MS_W'(5 * TEMP_STEP_MS));
        end else if (s == SEL_CALIFORNIA) begin
            patOn = ms < MS_W'(CAL_ON_MS);
        end else if (s == SEL_SYNC_A) begin
            patOn = ms < MS_W'(SYNC_PERIOD_MS - SYNC_GAP_A_MS);
        end else if (s == SEL_SYNC_B) begin
            patOn = ms < MS_W'(SYNC_PERIOD_MS - SYNC_GAP_B_MS);
        end else if (s == SEL_SYNC_C) begin
            patOn = ms < MS_W'(SYNC_PERIOD_MS - SYNC_GAP_C_MS);
        end else if (s == SEL_TWO_STAGE || isCan(s)) begin
            patOn = ms < MS_W'(ALERT_ON_MS);
        end else begin
            patOn = ms < MS_W'(MARCH_ON_MS);
        end
    endfunction : patOn

    // =========================================================
    // Pin synchronisers and millisecond tick
    logic [1:0] pinMeta_r, pinSync_r;
    logic [16:0] div_r, div_nxt;
    logic tick_r, tick_nxt;
    logic evacLvl;

    // Divider counts one millisecond; the tick is a one-cycle enable
    always_comb begin
        tick_nxt = 1'b0;
        div_nxt = div_r + 17'h00001;
        if (div_r == 17'(TICK_CYCLES - 1)) begin
            div_nxt = 17'h00000;
            tick_nxt = 1'b1;
        end
    end

    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            pinMeta_r <= 2'h0;
            pinSync_r <= 2'h0;
            div_r <= 17'h00000;
            tick_r <= 1'b0;
        end else begin
            pinMeta_r <= {manualEvacIn, drillIn};
            pinSync_r <= pinMeta_r;
            div_r <= div_nxt;
            tick_r <= tick_nxt;
        end
    end

    assign evacLvl = |pinSync_r;

    // =========================================================
    // Two-stage sequencer
    stage_e state_r, state_nxt;
    logic [TMR_W-1:0] tmr_r, tmr_nxt;
    logic twoStage, anyActive, keyHold, escalate, tmrDone;

    assign twoStage = (codingSel == SEL_TWO_STAGE) || isCan(codingSel);
    assign anyActive = |outActive;
    assign keyHold = ackKey || silenceKey;
    assign tmrDone = (tmr_r == TMR_W'(0)) && (codingSel != SEL_CAN_MANUAL);
    assign escalate = isCan(codingSel) && (evacLvl || qualifyingEvent);

    // Escalation outranks a same-cycle hold so a drill is never lost
    always_comb begin
        state_nxt = state_r;
        tmr_nxt = tmr_r;
        if (tick_r && tmr_r != TMR_W'(0)) tmr_nxt = tmr_r - TMR_W'(1);
        case (state_r)
            ST_IDLE: begin
                if (twoStage && anyActive) begin
                    state_nxt = ST_ALERT;
                    tmr_nxt = (codingSel == SEL_CAN3) ? TMR_W'(CAN3_TMO_MS)
                            : (codingSel == SEL_CAN5) ? TMR_W'(CAN5_TMO_MS)
                            : TMR_W'(BASIC_TMO_MS);
                end
            end
            ST_ALERT: begin
                if (escalate) state_nxt = ST_GENERAL;
                else if (keyHold) state_nxt = ST_HELD;
                else if (tick_r && tmrDone) state_nxt = ST_GENERAL;
                else if (fireAlarm && (codingSel == SEL_CAN3 || codingSel == SEL_CAN5))
                    tmr_nxt = (codingSel == SEL_CAN3) ? TMR_W'(CAN3_TMO_MS)
                            : TMR_W'(CAN5_TMO_MS);
            end
            ST_HELD: begin
                // Manual variant stays blocked once silenced first
                if (escalate && codingSel != SEL_CAN_MANUAL) state_nxt = ST_GENERAL;
            end
            ST_GENERAL: state_nxt = ST_GENERAL;
            default: state_nxt = ST_IDLE;
        endcase
        if (panelReset || !twoStage || !anyActive) state_nxt = ST_IDLE;
        // Manual reset with alarms still standing keeps the first stage only
        if (panelReset && anyActive && codingSel == SEL_CAN_MANUAL
            && state_r != ST_IDLE && state_r != ST_GENERAL) state_nxt = ST_HELD;
    end

    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            state_r <= ST_IDLE;
            tmr_r <= TMR_W'(0);
        end else begin
            state_r <= state_nxt;
            tmr_r <= tmr_nxt;
        end
    end

    // =========================================================
    // Per-output generators, silence and drive
    logic [MS_W-1:0] ms_r [NUM_OUT];
    logic [MS_W-1:0] ms_nxt [NUM_OUT];
    logic [3:0] silHorn_r, silHorn_nxt, silStrobe_r, silStrobe_nxt;
    logic [3:0] hornOut_r, hornOut_nxt, strobeOut_r, strobeOut_nxt;
    logic [3:0] outEn;
    logic generalStage_r, generalStage_nxt, genNow;

    assign genNow = (state_r == ST_GENERAL);

    genvar gi;
    generate
        for (gi = 0; gi < NUM_OUT; gi++) begin : g_out
            logic coded, pOn, syncOk;
            // Auto alert for general-zone coded outputs not on alarm signal
            assign outEn[gi] = outActive[gi] || (twoStage && state_r != ST_IDLE
                && mapGeneralZone[gi] && mapCodingZone[gi] && !mapAlarmSignal[gi]);
            assign coded = mapCodingZone[gi];
            assign syncOk = !isSync(codingSel) || mainBoard[gi];
            assign pOn = patOn(codingSel, genNow, ms_r[gi]);

            // Counter held at zero while idle so activation starts on-phase
            always_comb begin
                ms_nxt[gi] = ms_r[gi];
                if (!outEn[gi]) ms_nxt[gi] = '0;
                else if (tick_r) begin
                    if (ms_r[gi] >= periodOf(codingSel, genNow) - MS_W'(1))
                        ms_nxt[gi] = '0;
                    else ms_nxt[gi] = ms_r[gi] + MS_W'(1);
                end
                silHorn_nxt[gi] = silHorn_r[gi];
                silStrobe_nxt[gi] = silStrobe_r[gi];
                if (fireAlarm || panelReset || !outEn[gi]) begin
                    silHorn_nxt[gi] = 1'b0;
                    silStrobe_nxt[gi] = 1'b0;
                end
                // Silence beats a same-cycle resound
                if (silenceKey) begin
                    silHorn_nxt[gi] = 1'b1;
                    if (!(isSync(codingSel) && strobeType[gi] && hornOnlySilence[gi]))
                        silStrobe_nxt[gi] = 1'b1;
                end
                hornOut_nxt[gi] = outEn[gi] && !silHorn_r[gi]
                    && (!coded || !syncOk || pOn);
                strobeOut_nxt[gi] = outEn[gi] && !silStrobe_r[gi]
                    && (!coded || !syncOk || pOn);
            end

            always_ff @(posedge sys_clk or negedge rstn) begin
                if (!rstn) ms_r[gi] <= '0;
                else ms_r[gi] <= ms_nxt[gi];
            end
        end
    endgenerate

    assign generalStage_nxt = genNow;

    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            silHorn_r <= 4'h0;
            silStrobe_r <= 4'h0;
            hornOut_r <= 4'h0;
            strobeOut_r <= 4'h0;
            generalStage_r <= 1'b0;
        end else begin
            silHorn_r <= silHorn_nxt;
            silStrobe_r <= silStrobe_nxt;
            hornOut_r <= hornOut_nxt;
            strobeOut_r <= strobeOut_nxt;
            generalStage_r <= generalStage_nxt;
        end
    end

    assign hornOut = hornOut_r;
    assign strobeOut = strobeOut_r;
    assign generalStage = generalStage_r;

    // =========================================================
    // Checks
    property p_march_off;
        @(posedge sys_clk) disable iff (!rstn)
        (codingSel == SEL_MARCH && outEn[0] && mapCodingZone[0]
         && ms_r[0] == MS_W'(MARCH_ON_MS)) |=> !hornOut[0];
    endproperty
    a_march_off: assert property (p_march_off) else $error("march off phase wrong");

    property p_temp_gap;
        @(posedge sys_clk) disable iff (!rstn)
        (genNow && outEn[1] && mapCodingZone[1] && ms_r[1] == MS_W'(5 * TEMP_STEP_MS))
        |=> !hornOut[1];
    endproperty
    a_temp_gap: assert property (p_temp_gap) else $error("temporal gap wrong");

    property p_cal_on;
        @(posedge sys_clk) disable iff (!rstn)
        (codingSel == SEL_CALIFORNIA && outEn[0] && !silHorn_r[0]
         && ms_r[0] == MS_W'(CAL_ON_MS - 1)) |=> hornOut[0];
    endproperty
    a_cal_on: assert property (p_cal_on) else $error("california on phase wrong");

    property p_uncoded_steady;
        @(posedge sys_clk) disable iff (!rstn)
        (outEn[2] && !mapCodingZone[2] && !silHorn_r[2]) |=> hornOut[2];
    endproperty
    a_uncoded_steady: assert property (p_uncoded_steady) else $error("uncoded not steady");

    property p_drill_escalates;
        @(posedge sys_clk) disable iff (!rstn)
        (state_r == ST_ALERT && isCan(codingSel) && evacLvl && !panelReset && anyActive)
        |=> ##1 generalStage;
    endproperty
    a_drill_escalates: assert property (p_drill_escalates) else $error("drill missed");

    property p_hold_blocks;
        @(posedge sys_clk) disable iff (!rstn)
        (state_r == ST_HELD && !escalate) |=> state_r != ST_GENERAL;
    endproperty
    a_hold_blocks: assert property (p_hold_blocks) else $error("held stage escalated");

    property p_manual_blocked;
        @(posedge sys_clk) disable iff (!rstn)
        (state_r == ST_HELD && codingSel == SEL_CAN_MANUAL) |=> state_r != ST_GENERAL;
    endproperty
    a_manual_blocked: assert property (p_manual_blocked) else $error("manual re-armed");

    property p_horn_only;
        @(posedge sys_clk) disable iff (!rstn)
        (silenceKey && isSync(codingSel) && strobeType[0] && hornOnlySilence[0]
         && outEn[0] && !fireAlarm && !panelReset) |=> !silStrobe_r[0] || $past(silStrobe_r[0]);
    endproperty
    a_horn_only: assert property (p_horn_only) else $error("strobe silenced");

    property p_silence_all;
        @(posedge sys_clk) disable iff (!rstn)
        (silenceKey && !hornOnlySilence[1]) |=> ##1 (!hornOut[1] && !strobeOut[1]);
    endproperty
    a_silence_all: assert property (p_silence_all) else $error("circuit not silenced");
endmodule : nac_coding_pattern_generator

//--- nac_coding_pattern_generator_bench.sv
`timescale 1ns/1ps
`define CHK(a, b) begin num_checks++; if ((a) !== (b)) begin n_errors++; \
    $display("Error at %0t: got %0h expected %0h", $time, a, b); end end
module nac_coding_pattern_generator_bench;
    // Short tick keeps the slow codes inside the run budget
    localparam int TK = 2;
    logic sys_clk, rstn, clr;
    logic [3:0] codingSel, outActive, mapCodingZone, mapGeneralZone, mapAlarmSignal;
    logic [3:0] mainBoard, strobeType, hornOnlySilence, hornOut, strobeOut;
    logic fireAlarm, qualifyingEvent, ackKey, silenceKey, panelReset, drillIn, manualEvacIn;
    logic generalStage;
    int minOn, maxOn, minOff, maxOff, h0, s0, o1;
    int n_errors = 0;
    int num_checks = 0;

    nac_coding_pattern_generator #(.TICK_CYCLES(TK)) u_nac_coding_pattern_generator (
        .sys_clk(sys_clk), .rstn(rstn), .codingSel(codingSel), .outActive(outActive),
        .mapCodingZone(mapCodingZone), .mapGeneralZone(mapGeneralZone),
        .mapAlarmSignal(mapAlarmSignal), .mainBoard(mainBoard), .strobeType(strobeType),
        .hornOnlySilence(hornOnlySilence), .fireAlarm(fireAlarm),
        .qualifyingEvent(qualifyingEvent), .ackKey(ackKey), .silenceKey(silenceKey),
        .panelReset(panelReset), .drillIn(drillIn), .manualEvacIn(manualEvacIn),
        .hornOut(hornOut), .strobeOut(strobeOut), .generalStage(generalStage));
    nac_appliance_model u_nac_appliance_model (.sys_clk(sys_clk), .horn(hornOut[0]),
        .clr(clr), .minOn(minOn), .maxOn(maxOn), .minOff(minOff), .maxOff(maxOff));

    // =========================================================
    // Helpers
    initial begin
        sys_clk = 1'b0;
        forever #5 sys_clk = ~sys_clk;
    end
    // Expected run length in clock cycles for a span in milliseconds
    function automatic int ms2cyc(input int ms);
        return ms * TK;
    endfunction : ms2cyc
    task automatic tick(input int n);
        repeat (n) @(posedge sys_clk);
        #1;
    endtask : tick
    // Operator and event pulses: 0 ack, 1 silence, 2 fire, 3 qualifying, 4 reset
    task automatic pulse(input int k);
        @(posedge sys_clk);
        {panelReset, qualifyingEvent, fireAlarm, silenceKey, ackKey} <= 5'(1 << k);
        @(posedge sys_clk);
        {panelReset, qualifyingEvent, fireAlarm, silenceKey, ackKey} <= 5'h00;
    endtask : pulse
    task automatic start(input logic [3:0] sel);
        @(posedge sys_clk);
        rstn <= 1'b0;
        outActive <= 4'h0;
        codingSel <= sel;
        repeat (6) @(posedge sys_clk);
        rstn <= 1'b1;
        tick(1);
        `CHK(hornOut, 4'h0)
        @(posedge sys_clk);
        outActive <= 4'hF;
    endtask : start
    // Clear the monitor just after a rise, so only whole runs count
    task automatic settle;
        int i;
        for (i = 0; i < 4000 && hornOut[0] !== 1'b1; i++) tick(1);
        if (i == 4000) begin
            n_errors++;
            $display("Error at %0t: output 0 never rose", $time);
            wrap_up();
        end
        @(posedge sys_clk);
        clr <= 1'b1;
        @(posedge sys_clk);
        clr <= 1'b0;
        #1;
    endtask : settle
    task automatic stats(input int onMs, input int offLo, input int offHi);
        `CHK(minOn, ms2cyc(onMs))
        `CHK(maxOn, ms2cyc(onMs))
        `CHK(minOff, ms2cyc(offLo))
        `CHK(maxOff, ms2cyc(offHi))
    endtask : stats
    task automatic count_hi(input int n);
        h0 = 0;
        s0 = 0;
        o1 = 0;
        repeat (n) begin
            h0 += int'(hornOut[0] === 1'b1);
            s0 += int'(strobeOut[0] === 1'b1);
            o1 += int'(hornOut[1] !== 1'b0 || strobeOut[1] !== 1'b0);
            tick(1);
        end
    endtask : count_hi
    task automatic run_mode(input logic [3:0] sel, input int onMs, input int offLo,
                            input int offHi, input int period);
        int mism, low1, low3;
        mism = 0;
        low1 = 0;
        low3 = 0;
        start(sel);
        settle();
        repeat ((period + onMs) * TK + 10) begin
            mism += int'(hornOut[1] !== hornOut[0]);
            low1 += int'(hornOut[1] !== 1'b1);
            low3 += int'(hornOut[3] !== 1'b1);
            tick(1);
        end
        stats(onMs, offLo, offHi);
        `CHK(low3, 0)
        `CHK((sel > 4'h6) ? low1 : mism, 0)
        $display("Test done: coding mode %0h", sel);
    endtask : run_mode
    // Optional first key, then a cause: 0 drill, 1 evacuate, 2 qualifying, 3 none
    task automatic escalate(input int pre, input int cause, input logic exp);
        int i;
        if (pre >= 0) pulse(pre);
        if (cause < 2) begin
            @(posedge sys_clk);
            {manualEvacIn, drillIn} <= 2'(cause + 1);
        end else if (cause == 2) pulse(3);
        for (i = 0; i < 12 && generalStage !== 1'b1; i++) tick(1);
        `CHK(generalStage, exp)
        if (exp && i == 12) wrap_up();
        @(posedge sys_clk);
        {manualEvacIn, drillIn} <= 2'h0;
        $display("Test done: staging mode %0h", codingSel);
    endtask : escalate
    task automatic wrap_up;
        $display("Checks %0d, errors %0d", num_checks, n_errors);
        if (n_errors == 0 && num_checks > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask : wrap_up

    // =========================================================
    // Main sequence
    initial begin
        {rstn, clr, codingSel, outActive} = '0;
        {fireAlarm, qualifyingEvent, ackKey, silenceKey, panelReset} = '0;
        {drillIn, manualEvacIn} = '0;
        // Output 3 stands for a releasing circuit, kept off the coding zone
        mapCodingZone = 4'h7;
        {mapGeneralZone, mapAlarmSignal, mainBoard} = {4'h3, 4'h2, 4'h1};
        {strobeType, hornOnlySilence} = {4'h3, 4'h1};
        void'($urandom(89));
        run_mode(4'h0, 60000 / 120 / 2, 60000 / 120 / 2, 60000 / 120 / 2, 500);
        run_mode(4'h1, 500, 500, 1500, 4000);
        run_mode(4'h2, 10000, 5000, 5000, 15000);
        run_mode(4'h7, 1000 - nac_coding_pkg::SYNC_GAP_A_MS, 10, 10, 1000);
        run_mode(4'h8, 1000 - nac_coding_pkg::SYNC_GAP_B_MS, 20, 20, 1000);
        run_mode(4'h9, 1000 - nac_coding_pkg::SYNC_GAP_C_MS, 30, 30, 1000);
        // Random coding maps while active; coded outputs track output 0
        start(4'h0);
        for (int r = 0; r < 4; r++) begin
            @(posedge sys_clk);
            mapCodingZone <= {1'b0, 2'($urandom), 1'b1};
            tick($urandom_range(600, 3));
            for (int j = 1; j < 3; j++)
                `CHK(hornOut[j], mapCodingZone[j] ? hornOut[0] : 1'b1)
        end
        @(posedge sys_clk);
        mapCodingZone <= 4'h7;
        $display("Test done: random coding maps");
        // Silence in sync mode: horn-only code keeps strobe, fire resounds
        start(4'h7);
        tick(3);
        pulse(1);
        tick(3);
        count_hi(1100 * TK);
        `CHK(h0, 0)
        `CHK(s0 > 0, 1'b1)
        `CHK(o1, 0)
        pulse(2);
        tick(3);
        count_hi(1100 * TK);
        `CHK(h0 > 0, 1'b1)
        $display("Test done: sync silence");
        // Alert stage, drill escalation, then temporal general stage
        start(4'h4);
        pulse(2);
        settle();
        tick(4500 * TK + 10);
        stats(1500, 1500, 1500);
        escalate(-1, 0, 1'b1);
        settle();
        tick(2500 * TK);
        `CHK(maxOn, 500 * TK)
        start(4'h5);
        pulse(2);
        escalate(0, 1, 1'b1);
        start(4'h4);
        pulse(2);
        escalate(0, 2, 1'b1);
        start(4'h6);
        pulse(2);
        escalate(2, 3, 1'b0);
        escalate(-1, 2, 1'b1);
        start(4'h6);
        pulse(2);
        escalate(1, 0, 1'b0);
        start(4'h6);
        pulse(2);
        escalate(4, 2, 1'b0);
        start(4'h3);
        pulse(2);
        escalate(-1, 0, 1'b0);
        // Only output 2 raised: output 0 alerts by its zone map, output 1 stays dark
        @(posedge sys_clk);
        outActive <= 4'h4;
        tick(4);
        count_hi(ms2cyc(3000));
        `CHK(h0, ms2cyc(1500))
        `CHK(o1, 0)
        $display("Test done: automatic alert");
        wrap_up();
    end
endmodule : nac_coding_pattern_generator_bench

//--- nac_coding_pkg.sv
package nac_coding_pkg;
    // =========================================================
    // Geometry
    localparam int NUM_OUT = 4;
    localparam int MS_W = 14;
    localparam int TMR_W = 19;
    // =========================================================
    // Timing
    localparam int CLK_PERIOD_NS = 10;
    localparam int TICK_MS_NS = 1000000;
    localparam int TICK_CYCLES = TICK_MS_NS / CLK_PERIOD_NS;
    localparam int MARCH_PERIOD_MS = 60000 / 120;
    localparam int MARCH_ON_MS = MARCH_PERIOD_MS / 2;
    localparam int ALERT_PERIOD_MS = 60000 / 20;
    localparam int ALERT_ON_MS = ALERT_PERIOD_MS / 2;
    localparam int TEMP_STEP_MS = 500;
    localparam int TEMP_LONG_OFF_MS = 1500;
    localparam int TEMP_PERIOD_MS = 5 * TEMP_STEP_MS + TEMP_LONG_OFF_MS;
    localparam int CAL_ON_MS = 10000;
    localparam int CAL_OFF_MS = 5000;
    localparam int CAL_PERIOD_MS = CAL_ON_MS + CAL_OFF_MS;
    localparam int SYNC_PERIOD_MS = 1000;
    localparam int SYNC_GAP_A_MS = 10;
    localparam int SYNC_GAP_B_MS = 20;
    localparam int SYNC_GAP_C_MS = 30;
    localparam int BASIC_TMO_MS = 5 * 60000;
    localparam int CAN3_TMO_MS = 3 * 60000;
    localparam int CAN5_TMO_MS = 5 * 60000;
    // =========================================================
    // Global coding selection
    typedef enum logic [3:0] {
        SEL_MARCH = 4'h0,
        SEL_TEMPORAL = 4'h1,
        SEL_CALIFORNIA = 4'h2,
        SEL_TWO_STAGE = 4'h3,
        SEL_CAN3 = 4'h4,
        SEL_CAN5 = 4'h5,
        SEL_CAN_MANUAL = 4'h6,
        SEL_SYNC_A = 4'h7,
        SEL_SYNC_B = 4'h8,
        SEL_SYNC_C = 4'h9
    } coding_sel_e;
    // Two-stage sequencer states
    typedef enum logic [1:0] {
        ST_IDLE = 2'h0,
        ST_ALERT = 2'h1,
        ST_HELD = 2'h2,
        ST_GENERAL = 2'h3
    } stage_e;
endpackage : nac_coding_pkg
